// *** verilog/operand_field_decoder.sv ***
// Operand field decoder for the decode stage of a 32-bit core.
// Assumes instruction bytes and a load strobe from fetch, same clock.
`include "operand_decode_defs.svh"

module operand_field_decoder (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [7:0] modrm_in,
    input wire logic [7:0] sib_in,
    input wire logic [7:0] imm8_in,
    input wire logic width_in,
    input wire logic dir_in,
    input wire logic sext_in,
    input wire logic [3:0] cond_in,
    input wire logic [1:0] special_class_in,
    input wire logic flag_overflow,
    input wire logic flag_carry,
    input wire logic flag_zero,
    input wire logic flag_sign,
    input wire logic flag_parity,
    output logic is_register_q,
    output logic [3:0] reg_sel_q,
    output logic [3:0] rm_sel_q,
    output logic [3:0] src_sel_q,
    output logic [3:0] dst_sel_q,
    output logic rm_is_dest_q,
    output logic base_valid_q,
    output logic [2:0] base_sel_q,
    output logic index_valid_q,
    output logic [2:0] index_sel_q,
    output logic [3:0] scale_mult_q,
    output logic addr_defined_q,
    output operand_decode_pkg::segment_type segment_q,
    output operand_decode_pkg::disp_size_type disp_size_q,
    output logic [31:0] imm_ext_q,
    output logic cond_true_q,
    output operand_decode_pkg::special_reg_type special_sel_q,
    output logic special_valid_q
);
    import operand_decode_pkg::*;

    // ========================================
    // Decode stage capture
    // ========================================
    logic [7:0] modrm_q, sib_q, imm8_q;
    logic width_q, dir_q, sext_q;
    logic [3:0] cond_q;
    logic [1:0] class_q;

    // Capture instruction bytes on load
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            modrm_q <= `BYTE_RESET;
            sib_q <= `BYTE_RESET;
            imm8_q <= `BYTE_RESET;
        end else if (load) begin
            modrm_q <= modrm_in;
            sib_q <= sib_in;
            imm8_q <= imm8_in;
        end
    end

    // Capture the opcode bits that travel with the bytes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            width_q <= 1'b0;
            dir_q <= 1'b0;
            sext_q <= 1'b0;
        end else if (load) begin
            width_q <= width_in;
            dir_q <= dir_in;
            sext_q <= sext_in;
        end
    end

    // Capture the condition and special register class
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cond_q <= `COND_RESET;
            class_q <= `SPECIAL_CONTROL;
        end else if (load) begin
            cond_q <= cond_in;
            class_q <= special_class_in;
        end
    end

    // ========================================
    // Field extraction
    // ========================================
    wire logic [1:0] mod_f = modrm_q[`MOD_HI:`MOD_LO];
    wire logic [2:0] reg_f = modrm_q[`REG_HI:`REG_LO];
    wire logic [2:0] rm_f = modrm_q[`RM_HI:`RM_LO];
    wire logic [1:0] scale_f = sib_q[`SCALE_HI:`SCALE_LO];
    wire logic [2:0] index_f = sib_q[`INDEX_HI:`INDEX_LO];
    wire logic [2:0] base_f = sib_q[`BASE_HI:`BASE_LO];

    // ========================================
    // Register operands
    // ========================================
    // Width bit on top: 0 byte regs AL..BH, 1 32-bit regs
    wire logic is_reg_d = (mod_f == `MOD_REG);
    wire logic [3:0] reg_d = {width_q, reg_f};
    wire logic [3:0] rm_d = {width_q, rm_f};

    // ========================================
    // Operand roles
    // ========================================
    // Direction 0: reg is source; 1: reg is destination
    wire logic [3:0] src_d = dir_q ? rm_d : reg_d;
    wire logic [3:0] dst_d = dir_q ? reg_d : rm_d;

    // ========================================
    // Effective address formation
    // ========================================
    wire logic has_sib = !is_reg_d && (rm_f == `CODE_SIB);
    wire logic base_is_frame = (base_f == `CODE_FRAME_BASE);
    wire logic base_is_stack = (base_f == `CODE_STACK_BASE);
    wire logic nodisp = (mod_f == `MOD_NODISP);
    // Displacement width taken from mod, except base 101 in mod 00
    wire logic mod_disp8 = (mod_f == `MOD_DISP8);
    wire logic mod_disp32 = (mod_f == `MOD_DISP32);
    // Frame code with no displacement means disp32 only
    wire logic base_valid_d = is_reg_d ? 1'b0 :
        has_sib ? !(nodisp && base_is_frame) :
        !(nodisp && rm_f == `CODE_FRAME_BASE);
    wire logic [2:0] base_d = has_sib ? base_f : rm_f;
    wire logic index_valid_d = has_sib &&
        (index_f != `CODE_NO_INDEX);
    // One-hot multiplier: bit n set for scale code n
    wire logic [3:0] scale_d;
    genvar sc;
    generate
        for (sc = 0; sc < $bits(scale_d); sc = sc + 1) begin : g_scale
            assign scale_d[sc] = (scale_f == sc);
        end
    endgenerate
    // No index with a scale other than x1 leaves address undefined
    wire logic addr_def_d = !(has_sib && index_f == `CODE_NO_INDEX &&
        scale_f != `SCALE_X1);

    // ========================================
    // Segment and displacement
    // ========================================
    // Stack segment for stack base, or frame base with displacement
    wire logic stack_seg = has_sib ?
        (base_is_stack || (base_is_frame && !nodisp)) :
        (rm_f == `CODE_FRAME_BASE && !nodisp);
    wire segment_type seg_d = (!is_reg_d && stack_seg) ?
        seg_stack_type_v : seg_data_type_v;

    // Displacement size from mod, disp32 for base 101 in mod 00
    wire disp_size_type disp_d =
        is_reg_d ? disp_none_type_v :
        mod_disp8 ? disp_8bit_type_v :
        mod_disp32 ? disp_32bit_type_v :
        ((has_sib ? base_f : rm_f) == `CODE_FRAME_BASE) ?
            disp_32bit_type_v : disp_none_type_v;

    // ========================================
    // Immediate sign extension
    // ========================================
    // Only byte immediates with the bit set take the sign
    wire logic [23:0] imm_fill;
    genvar fb;
    generate
        for (fb = 0; fb < $bits(imm_fill); fb = fb + 1) begin : g_fill
            assign imm_fill[fb] = sext_q & imm8_q[`IMM_SIGN];
        end
    endgenerate
    wire logic [31:0] imm_d = {imm_fill, imm8_q};

    // ========================================
    // Condition test
    // ========================================
    logic cond_true_d;
    condition_decode condition_decode_inst (
        .cond_code(cond_q),
        .flag_overflow(flag_overflow),
        .flag_carry(flag_carry),
        .flag_zero(flag_zero),
        .flag_sign(flag_sign),
        .flag_parity(flag_parity),
        .cond_true(cond_true_d)
    );

    // ========================================
    // Special register field
    // ========================================
    special_reg_type sreg_d;
    logic sreg_valid_d;
    wire logic [2:0] eee_f = reg_f;

    // Map class and eee code to a special register select
    always_comb begin
        sreg_d = sreg_none;
        unique case (class_q)
            `SPECIAL_CONTROL: begin
                if (eee_f == `EEE_CTRL0) sreg_d = control_reg_0;
                if (eee_f == `EEE_CTRL2) sreg_d = control_reg_2;
                if (eee_f == `EEE_CTRL3) sreg_d = control_reg_3;
            end
            `SPECIAL_DEBUG: begin
                if (eee_f == `EEE_BP0) sreg_d = breakpoint_reg_0;
                if (eee_f == `EEE_BP1) sreg_d = breakpoint_reg_1;
                if (eee_f == `EEE_BP2) sreg_d = breakpoint_reg_2;
                if (eee_f == `EEE_BP3) sreg_d = breakpoint_reg_3;
                if (eee_f == `EEE_DSTAT) sreg_d = debug_status_reg;
                if (eee_f == `EEE_DCTL) sreg_d = debug_control_reg;
            end
            `SPECIAL_TEST: begin
                if (eee_f == `EEE_TEST6) sreg_d = test_reg_6;
                if (eee_f == `EEE_TEST7) sreg_d = test_reg_7;
            end
            default: sreg_d = sreg_none;
        endcase
        // Reserved codes flagged, no register selected
        sreg_valid_d = (sreg_d != sreg_none);
    end

    // ========================================
    // Output registers
    // ========================================
    // Register operand outputs, one edge after capture
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            is_register_q <= 1'b0;
            reg_sel_q <= 4'h0;
            rm_sel_q <= 4'h0;
            src_sel_q <= 4'h0;
            dst_sel_q <= 4'h0;
            rm_is_dest_q <= 1'b1;
        end else begin
            is_register_q <= is_reg_d;
            reg_sel_q <= reg_d;
            rm_sel_q <= rm_d;
            src_sel_q <= src_d;
            dst_sel_q <= dst_d;
            rm_is_dest_q <= !dir_q;
        end
    end

    // Base and index outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            base_valid_q <= 1'b0;
            base_sel_q <= 3'h0;
            index_valid_q <= 1'b0;
            index_sel_q <= 3'h0;
        end else begin
            base_valid_q <= base_valid_d;
            base_sel_q <= base_d;
            index_valid_q <= index_valid_d;
            index_sel_q <= index_f;
        end
    end

    // Scale, definedness, segment and displacement outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scale_mult_q <= `SCALE_RESET;
            addr_defined_q <= 1'b1;
            segment_q <= seg_data_type_v;
            disp_size_q <= disp_none_type_v;
        end else begin
            scale_mult_q <= scale_d;
            addr_defined_q <= addr_def_d;
            segment_q <= seg_d;
            disp_size_q <= disp_d;
        end
    end

    // Immediate and condition outputs; flags are sampled live here
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            imm_ext_q <= 32'h00000000;
            cond_true_q <= 1'b0;
        end else begin
            imm_ext_q <= imm_d;
            cond_true_q <= cond_true_d;
        end
    end

    // Special register outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            special_sel_q <= sreg_none;
            special_valid_q <= 1'b0;
        end else begin
            special_sel_q <= sreg_d;
            special_valid_q <= sreg_valid_d;
        end
    end
endmodule

// *** shared/operand_decode_defs.svh ***
// Constants for the operand field decoder.
// Assumes inclusion by bare name from the design files.
`ifndef OPERAND_DECODE_DEFS_SVH
`define OPERAND_DECODE_DEFS_SVH

// mod r/m byte fields
`define MOD_HI 7
`define MOD_LO 6
`define REG_HI 5
`define REG_LO 3
`define RM_HI 2
`define RM_LO 0
// s-i-b byte fields
`define SCALE_HI 7
`define SCALE_LO 6
`define INDEX_HI 5
`define INDEX_LO 3
`define BASE_HI 2
`define BASE_LO 0
// mod codes
`define MOD_NODISP 2'h0
`define MOD_DISP8 2'h1
`define MOD_DISP32 2'h2
`define MOD_REG 2'h3
// Special code points
`define CODE_SIB 3'h4
`define CODE_NO_INDEX 3'h4
`define CODE_STACK_BASE 3'h4
`define CODE_FRAME_BASE 3'h5
`define SCALE_X1 2'h0
// Immediate sign position
`define IMM_SIGN 7
// Special-register class codes
`define SPECIAL_CONTROL 2'h0
`define SPECIAL_DEBUG 2'h1
`define SPECIAL_TEST 2'h2
`define EEE_CTRL0 3'h0
`define EEE_CTRL2 3'h2
`define EEE_CTRL3 3'h3
`define EEE_BP0 3'h0
`define EEE_BP1 3'h1
`define EEE_BP2 3'h2
`define EEE_BP3 3'h3
`define EEE_DSTAT 3'h6
`define EEE_DCTL 3'h7
`define EEE_TEST6 3'h6
`define EEE_TEST7 3'h7
// Reset values
`define BYTE_RESET 8'h00
`define COND_RESET 4'h0
`define SCALE_RESET 4'h1

`endif

// *** shared/operand_decode_pkg.sv ***
// Types for the operand field decoder.
// Assumes nothing of its surroundings.
package operand_decode_pkg;
    // Default segment of the effective address
    typedef enum logic [1:0] {
        seg_data_type_v = 2'h0,
        seg_stack_type_v = 2'h1
    } segment_type;

    typedef enum logic [1:0] {
        disp_none_type_v = 2'h0,
        disp_8bit_type_v = 2'h1,
        disp_32bit_type_v = 2'h3
    } disp_size_type;

    // Special register selects
    typedef enum logic [3:0] {
        sreg_none = 4'h0,
        control_reg_0 = 4'h1,
        control_reg_2 = 4'h3,
        control_reg_3 = 4'h2,
        breakpoint_reg_0 = 4'h6,
        breakpoint_reg_1 = 4'h7,
        breakpoint_reg_2 = 4'h5,
        breakpoint_reg_3 = 4'h4,
        debug_status_reg = 4'hc,
        debug_control_reg = 4'hd,
        test_reg_6 = 4'hf,
        test_reg_7 = 4'he
    } special_reg_type;
endpackage

// *** verilog/condition_decode.sv ***
// Condition field decoder: four-bit test code into a true/false outcome.
// Assumes flags come from the same clock domain, registered upstream.
`include "operand_decode_defs.svh"

module condition_decode (
    input wire logic [3:0] cond_code,
    input wire logic flag_overflow,
    input wire logic flag_carry,
    input wire logic flag_zero,
    input wire logic flag_sign,
    input wire logic flag_parity,
    output logic cond_true
);
    import operand_decode_pkg::*;

    // ========================================
    // Base tests by upper three bits
    // ========================================
    wire logic [7:0] test_vec;
    assign test_vec[0] = flag_overflow;
    assign test_vec[1] = flag_carry;
    assign test_vec[2] = flag_zero;
    assign test_vec[3] = flag_carry | flag_zero;
    assign test_vec[4] = flag_sign;
    assign test_vec[5] = flag_parity;
    assign test_vec[6] = flag_sign ^ flag_overflow;
    assign test_vec[7] = (flag_sign ^ flag_overflow) | flag_zero;

    // Low bit inverts the chosen test
    assign cond_true = test_vec[cond_code[3:1]] ^ cond_code[0];
endmodule

// *** bench/operand_field_decoder_props.sv ***
// Checker for the operand field decoder outputs.
// Assumes binding onto operand_field_decoder, same clock and reset.
// ========================================
// Checker
module decoder_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [7:0] modrm_in,
    input wire logic [7:0] sib_in,
    input wire logic [7:0] imm8_in,
    input wire logic width_in,
    input wire logic dir_in,
    input wire logic sext_in,
    input wire logic is_register_q,
    input wire logic [3:0] reg_sel_q,
    input wire logic [3:0] rm_sel_q,
    input wire logic [3:0] src_sel_q,
    input wire logic [3:0] dst_sel_q,
    input wire logic index_valid_q,
    input wire logic [3:0] scale_mult_q,
    input wire logic addr_defined_q,
    input wire logic [31:0] imm_ext_q,
    input wire operand_decode_pkg::segment_type segment_q,
    input wire operand_decode_pkg::disp_size_type disp_size_q
);
    import operand_decode_pkg::*;
    logic [7:0] m1, m2, s1, s2, i1, i2;
    logic [2:0] c1, c2;
    logic sib;
    // Two-deep copy of the loaded fields
    always_ff @(posedge sys_clk) begin
        m1 <= modrm_in;
        m2 <= m1;
        s1 <= sib_in;
        s2 <= s1;
        i1 <= imm8_in;
        i2 <= i1;
        c1 <= {width_in, dir_in, sext_in};
        c2 <= c1;
    end
    assign sib = (m2[7:6] != 2'h3) && (m2[2:0] == 3'h4);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_mod; load |-> ##2 is_register_q == (m2[7:6] == 2'h3);
    endproperty
    a_mod: assert property (p_mod) else $error("mod decode");
    property p_reg; load |-> ##2 reg_sel_q == {c2[2], m2[5:3]} &&
        rm_sel_q == {c2[2], m2[2:0]}; endproperty
    a_reg: assert property (p_reg) else $error("reg select");
    property p_dir; load |-> ##2
        src_sel_q == {c2[2], (c2[1] ? m2[2:0] : m2[5:3])} &&
        dst_sel_q == {c2[2], (c2[1] ? m2[5:3] : m2[2:0])}; endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_scale; load ##2 sib |-> scale_mult_q == 4'h1 << s2[7:6];
    endproperty
    a_scale: assert property (p_scale) else $error("scale");
    property p_idx; load ##2 sib |-> index_valid_q == (s2[5:3] != 3'h4);
    endproperty
    a_idx: assert property (p_idx) else $error("index");
    property p_undef; load ##2 sib |->
        addr_defined_q == !(s2[5:3] == 3'h4 && s2[7:6] != 2'h0); endproperty
    a_undef: assert property (p_undef) else $error("defined");
    property p_disp; load ##2 sib |-> disp_size_q == (m2[7:6] == 2'h1 ?
        disp_8bit_type_v : (m2[7:6] == 2'h2 || s2[2:0] == 3'h5) ?
        disp_32bit_type_v : disp_none_type_v); endproperty
    a_disp: assert property (p_disp) else $error("disp size");
    property p_seg; load ##2 sib |-> (segment_q == seg_stack_type_v) ==
        (s2[2:0] == 3'h4 || (s2[2:0] == 3'h5 && m2[7:6] != 2'h0));
    endproperty
    a_seg: assert property (p_seg) else $error("segment");
    property p_sext; load |-> ##2 imm_ext_q ==
        (c2[0] ? {{24{i2[7]}}, i2} : {24'h0, i2}); endproperty
    a_sext: assert property (p_sext) else $error("sign extend");
endmodule

bind operand_field_decoder decoder_props decoder_props_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(load),
    .modrm_in(modrm_in),
    .sib_in(sib_in),
    .imm8_in(imm8_in),
    .width_in(width_in),
    .dir_in(dir_in),
    .sext_in(sext_in),
    .is_register_q(is_register_q),
    .reg_sel_q(reg_sel_q),
    .rm_sel_q(rm_sel_q),
    .src_sel_q(src_sel_q),
    .dst_sel_q(dst_sel_q),
    .index_valid_q(index_valid_q),
    .scale_mult_q(scale_mult_q),
    .addr_defined_q(addr_defined_q),
    .imm_ext_q(imm_ext_q),
    .segment_q(segment_q),
    .disp_size_q(disp_size_q)
);

// *** bench/operand_field_decoder_test.sv ***
// Self-checking bench for the operand field decoder.
// Assumes the design and the package are compiled first.
// ========================================
// Bench
module operand_field_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import operand_decode_pkg::*;
    logic sys_clk = 0, nrst = 0, load = 0, width_in = 0, dir_in = 0;
    logic sext_in = 0, flag_overflow = 0, flag_carry = 0, flag_zero = 0;
    logic flag_sign = 0, flag_parity = 0;
    logic [7:0] modrm_in = 0, sib_in = 0, imm8_in = 0;
    logic [3:0] cond_in = 0;
    logic [1:0] special_class_in = 2'h3;
    logic is_register_q, rm_is_dest_q, base_valid_q, index_valid_q;
    logic addr_defined_q, cond_true_q, special_valid_q;
    logic [3:0] reg_sel_q, rm_sel_q, src_sel_q, dst_sel_q, scale_mult_q;
    logic [2:0] base_sel_q, index_sel_q;
    logic [31:0] imm_ext_q;
    segment_type segment_q;
    disp_size_type disp_size_q;
    special_reg_type special_sel_q;
    int err_total = 0, n_checks = 0;
    operand_field_decoder operand_field_decoder_inst (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(load),
        .modrm_in(modrm_in),
        .sib_in(sib_in),
        .imm8_in(imm8_in),
        .width_in(width_in),
        .dir_in(dir_in),
        .sext_in(sext_in),
        .cond_in(cond_in),
        .special_class_in(special_class_in),
        .flag_overflow(flag_overflow),
        .flag_carry(flag_carry),
        .flag_zero(flag_zero),
        .flag_sign(flag_sign),
        .flag_parity(flag_parity),
        .is_register_q(is_register_q),
        .reg_sel_q(reg_sel_q),
        .rm_sel_q(rm_sel_q),
        .src_sel_q(src_sel_q),
        .dst_sel_q(dst_sel_q),
        .rm_is_dest_q(rm_is_dest_q),
        .base_valid_q(base_valid_q),
        .base_sel_q(base_sel_q),
        .index_valid_q(index_valid_q),
        .index_sel_q(index_sel_q),
        .scale_mult_q(scale_mult_q),
        .addr_defined_q(addr_defined_q),
        .segment_q(segment_q),
        .disp_size_q(disp_size_q),
        .imm_ext_q(imm_ext_q),
        .cond_true_q(cond_true_q),
        .special_sel_q(special_sel_q),
        .special_valid_q(special_valid_q)
    );
    always #25 sys_clk = ~sys_clk;
    // Load once, then wait until the decode shows
    task automatic go;
        load = 1'b1;
        @(negedge sys_clk);
        load = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (e !== g) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic t_regs;
        for (int k = 0; k < 128; k++) begin
            modrm_in = {2'h3, k[5:0]};
            width_in = k[6];
            go;
            chk("is_reg", 1, is_register_q);
            chk("reg_sel", {width_in, modrm_in[5:3]}, reg_sel_q);
            chk("rm_sel", {width_in, modrm_in[2:0]}, rm_sel_q);
            chk("reg_base_v", 0, base_valid_q);
            chk("reg_disp", disp_none_type_v, disp_size_q);
        end
        $display("register select test done");
    endtask
    task automatic t_sib;
        logic bv;
        for (int k = 0; k < 64; k++) begin
            if (k[4:3] == 2'h3) continue;
            modrm_in = {k[4:3], 3'h0, k[5] ? k[2:0] : 3'h4};
            sib_in = {5'h01, k[2:0]};
            bv = !(k[4:3] == 0 && k[2:0] == 5);
            go;
            chk("base_v", bv, base_valid_q);
            if (bv) chk("base", k[2:0], base_sel_q);
            chk("idx_v", !k[5] || k[2:0] == 4, index_valid_q);
            chk("seg", k[2:0] == 4 || (k[4:3] != 0 && k[2:0] == 5),
                segment_q);
            chk("disp", k[4:3] == 1 ? 1 : (k[4:3] == 2 || !bv) ? 3 : 0,
                disp_size_q);
        end
        $display("base form test done");
    endtask
    task automatic t_idx;
        for (int k = 0; k < 32; k++) begin
            modrm_in = 8'h04;
            sib_in = {k[4:0], 3'h0};
            go;
            chk("scale", 1 << k[4:3], scale_mult_q);
            chk("idx_v", k[2:0] != 4, index_valid_q);
            if (k[2:0] != 4) chk("idx", k[2:0], index_sel_q);
            chk("def", !(k[2:0] == 4 && k[4:3] != 0),
                addr_defined_q);
        end
        $display("index test done");
    endtask
    // Back-to-back loads; the second must win
    task automatic t_dir;
        modrm_in = 8'hd1;
        width_in = 1'b1;
        load = 1'b1;
        @(negedge sys_clk);
        dir_in = 1'b1;
        go;
        chk("src", 4'h9, src_sel_q);
        chk("dst", 4'ha, dst_sel_q);
        chk("rm_dst", 0, rm_is_dest_q);
        dir_in = 1'b0;
        go;
        chk("src", 4'ha, src_sel_q);
        chk("dst", 4'h9, dst_sel_q);
        chk("rm_dst", 1, rm_is_dest_q);
        $display("direction test done");
    endtask
    task automatic t_imm;
        for (int k = 0; k < 4; k++) begin
            imm8_in = k[0] ? 8'h80 : 8'h7f;
            sext_in = k[1];
            go;
            chk("imm", k == 3 ? 32'hffffff80 : {24'h0, imm8_in},
                imm_ext_q);
        end
        $display("immediate test done");
    endtask
    task automatic t_cond;
        logic [4:0] f;
        logic e;
        for (int k = 0; k < 512; k++) begin
            f = k[8:4];
            cond_in = k[3:0];
            {flag_parity, flag_sign, flag_zero, flag_carry, flag_overflow} = f;
            go;
            // Tests in code order
            case (cond_in[3:1])
                0: e = f[0];
                1: e = f[1];
                2: e = f[2];
                3: e = f[1] | f[2];
                4: e = f[3];
                5: e = f[4];
                6: e = f[3] ^ f[0];
                default: e = (f[3] ^ f[0]) | f[2];
            endcase
            chk("cond", e ^ cond_in[0], cond_true_q);
        end
        $display("condition test done");
    endtask
    task automatic t_spec;
        special_reg_type es;
        for (int k = 0; k < 32; k++) begin
            special_class_in = k[4:3];
            modrm_in = {2'h3, k[2:0], 3'h0};
            go;
            es = sreg_none;
            case (k[4:0])
                5'h00: es = control_reg_0;
                5'h02: es = control_reg_2;
                5'h03: es = control_reg_3;
                5'h08: es = breakpoint_reg_0;
                5'h09: es = breakpoint_reg_1;
                5'h0a: es = breakpoint_reg_2;
                5'h0b: es = breakpoint_reg_3;
                5'h0e: es = debug_status_reg;
                5'h0f: es = debug_control_reg;
                5'h16: es = test_reg_6;
                5'h17: es = test_reg_7;
                default: es = sreg_none;
            endcase
            chk("sreg", es, special_sel_q);
            chk("sreg_v", es != sreg_none, special_valid_q);
        end
        $display("special register test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("rst_scale", 1, scale_mult_q);
        chk("rst_rm_dst", 1, rm_is_dest_q);
        nrst = 1'b1;
        @(negedge sys_clk);
        @(negedge sys_clk);
        chk("rst_base", 1, base_valid_q);
        chk("rst_seg", seg_data_type_v, segment_q);
        chk("rst_reg", 0, is_register_q);
        t_regs;
        t_sib;
        t_idx;
        t_dir;
        t_imm;
        t_cond;
        t_spec;
        close_out;
    end
    // Watchdog well past the expected run length
    initial begin
        #400000;
        err_total++;
        close_out;
    end
endmodule
